// *** shared/fcf_pkg.sv ***
package fcf_pkg;
  // ahb register map
  localparam logic [31:0] addr_upper_address_segment = 32'h0000_0000;
  localparam logic [31:0] addr_mode_control = 32'h0000_0004;
  localparam logic [31:0] addr_status = 32'h0000_0008;
  localparam logic [31:0] addr_last_command = 32'h0000_000C;
  localparam logic [31:0] addr_last_address = 32'h0000_0010;
  localparam logic [7:0] reset_upper_address_byte = 8'h00;
  localparam logic [1:0] reset_dummy_sel = 2'h0;
  // mode_control fields
  localparam int pos_dummy_count_sel_lo = 6;
  localparam int pos_dummy_count_sel_hi = 7;
  localparam int pos_four_byte_mode = 0;
  localparam int pos_quad_lines_enable_bit = 1;
  // opcodes
  localparam logic [7:0] op_read = 8'h03;
  localparam logic [7:0] op_fast_read = 8'h0B;
  localparam logic [7:0] dual_io_fetch_cmd = 8'hBB;
  localparam logic [7:0] dual_out_fetch_cmd = 8'h3B;
  localparam logic [7:0] quad_io_fetch_cmd = 8'hEB;
  localparam logic [7:0] quad_io_fetch_top_cmd = 8'hEA;
  localparam logic [7:0] quad_out_fetch_cmd = 8'h6B;
  localparam logic [7:0] page_program_cmd = 8'h02;
  localparam logic [7:0] quad_page_program_cmd = 8'h38;
  localparam logic [7:0] wipe_4k_cmd = 8'h20;
  localparam logic [7:0] wipe_32k_cmd = 8'h52;
  localparam logic [7:0] wipe_64k_cmd = 8'hD8;
  localparam logic [7:0] chip_wipe_cmd_a = 8'h60;
  localparam logic [7:0] chip_wipe_cmd_b = 8'hC7;
  localparam logic [7:0] quad_mode_enter_cmd = 8'h35;
  localparam logic [7:0] quad_mode_exit_cmd = 8'hF5;
  // command kinds reported to the array side
  localparam logic [2:0] kind_none = 3'h0;
  localparam logic [2:0] kind_program = 3'h1;
  localparam logic [2:0] kind_wipe_4k = 3'h2;
  localparam logic [2:0] kind_wipe_32k = 3'h3;
  localparam logic [2:0] kind_wipe_64k = 3'h4;
  localparam logic [2:0] kind_chip_wipe = 3'h5;
  localparam logic [3:0] quad_io_dummy = 4'h6;
  localparam logic [3:0] dummy_base = 4'h8;
  typedef enum logic [2:0] {
    fcf_idle_st, fcf_opcode_st, fcf_addr_st, fcf_dummy_st, fcf_data_st, fcf_ignore_st
  } fcf_state_type;
endpackage

// *** src/fcf_front_end.sv ***
// Implementation choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module fcf_front_end (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic haddr_sel,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe_n,
  input wire logic [7:0] array_rdata,
  output logic [24:0] array_addr,
  output logic array_rd_stb,
  output logic [7:0] prog_data,
  output logic prog_stb,
  output logic [2:0] exec_kind,
  output logic exec_stb
);
  import fcf_pkg::*;
  typedef struct packed {
    logic [7:0] upper_address_byte;
    logic [1:0] dummy_sel;
    logic four_byte_mode;
    logic quad_lines_enable_bit;
    logic quad_command_mode;
    logic [2:0] sclk_sync;
    logic [1:0] cs_sync;
    logic [7:0] io_s1;
    logic [3:0] io_s2;
    fcf_state_type state;
    logic [7:0] shift;
    logic [3:0] bit_cnt;
    logic [2:0] byte_cnt;
    logic [3:0] dummy_left;
    logic [7:0] opcode;
    logic [1:0] width_in;
    logic [1:0] width_out;
    logic is_read;
    logic [2:0] kind;
    logic [24:0] addr;
    logic [7:0] out_shift;
    logic [3:0] io_out;
    logic [3:0] io_oe_n;
    logic bus_pend;
    logic bus_write;
    logic [31:0] bus_addr;
    logic [31:0] hrdata;
    logic [24:0] array_addr;
    logic array_rd_stb;
    logic [7:0] prog_data;
    logic prog_stb;
    logic [2:0] exec_kind;
    logic exec_stb;
    logic [7:0] last_cmd;
    logic [24:0] last_addr;
  } fcf_core_type;
  fcf_core_type r;
  fcf_core_type next_r;
  // bits per serial clock for a lane width code 0=1,1=2,2=4
  function automatic logic [3:0] fcf_step(input logic [1:0] w);
    case (w)
      2'd1: fcf_step = 4'd2;
      2'd2: fcf_step = 4'd4;
      default: fcf_step = 4'd1;
    endcase
  endfunction
  // bits a lane group delivers
  function automatic logic [7:0] fcf_shift_in(input logic [7:0] s, input logic [1:0] w,
                                              input logic [3:0] d);
    case (w)
      2'd1: fcf_shift_in = {s[5:0], d[1:0]};
      2'd2: fcf_shift_in = {s[3:0], d[3:0]};
      default: fcf_shift_in = {s[6:0], d[0]};
    endcase
  endfunction
  logic sclk_rise;
  logic sclk_fall;
  logic cs_active;
  logic [7:0] in_byte;
  logic [3:0] next_bits;
  logic [7:0] rd_word;
  assign sclk_rise = r.sclk_sync[1] & ~r.sclk_sync[2];
  assign sclk_fall = ~r.sclk_sync[1] & r.sclk_sync[2];
  assign cs_active = ~r.cs_sync[1];
  always_comb begin
    next_r = r;
    in_byte = 8'h00;
    next_bits = 4'h0;
    rd_word = 8'h00;
    next_r.array_rd_stb = 1'b0;
    next_r.prog_stb = 1'b0;
    next_r.exec_stb = 1'b0;
    // clock and select pins pass two flops before use, data pins three
    next_r.sclk_sync = {r.sclk_sync[1:0], sclk};
    next_r.cs_sync = {r.cs_sync[0], cs_n};
    next_r.io_s1 = {r.io_s1[3:0], io_in};
    next_r.io_s2 = r.io_s1[7:4];
    // register bus: zero wait states, address phase latched
    if (r.bus_pend && r.bus_write) begin
      case (r.bus_addr)
        addr_upper_address_segment: begin
          // eight bits, only bit 0 kept
          next_r.upper_address_byte = {7'h00, hwdata[0]};
        end
        addr_mode_control: begin
          // dummy select bits 6 and 7
          next_r.dummy_sel = {hwdata[pos_dummy_count_sel_hi], hwdata[pos_dummy_count_sel_lo]};
          next_r.four_byte_mode = hwdata[pos_four_byte_mode];
          next_r.quad_lines_enable_bit = hwdata[pos_quad_lines_enable_bit];
        end
        default: begin
        end
      endcase
    end
    next_r.bus_pend = 1'b0;
    if (hsel && hready && htrans[1]) begin
      next_r.bus_pend = 1'b1;
      next_r.bus_write = hwrite;
      next_r.bus_addr = {haddr[31:2], 2'b00};
      if (!hwrite) begin
        case ({haddr[31:2], 2'b00})
          addr_upper_address_segment: next_r.hrdata = {24'h0, 7'h00, r.upper_address_byte[0]};
          addr_mode_control: next_r.hrdata = {24'h0, r.dummy_sel, 4'h0,
                                              r.quad_lines_enable_bit, r.four_byte_mode};
          addr_status: next_r.hrdata = {28'h0, r.state == fcf_data_st, r.quad_command_mode,
                                        r.quad_lines_enable_bit, cs_active};
          addr_last_command: next_r.hrdata = {24'h0, r.last_cmd};
          addr_last_address: next_r.hrdata = {7'h0, r.last_addr};
          default: next_r.hrdata = 32'h0000_0000;
        endcase
      end
    end
    if (!cs_active) begin
      // deselect mid-byte rejects program, erase, mode switches
      if (r.state != fcf_idle_st && r.bit_cnt == 4'd0) begin
        if (r.state == fcf_opcode_st && r.byte_cnt == 3'd1) begin
          // enter quad mode, enable bit untouched
          if (r.opcode == quad_mode_enter_cmd && !r.quad_command_mode)
            next_r.quad_command_mode = 1'b1;
          if (r.opcode == quad_mode_exit_cmd && r.quad_command_mode)
            next_r.quad_command_mode = 1'b0;
          if (r.opcode == chip_wipe_cmd_a || r.opcode == chip_wipe_cmd_b) begin
            next_r.exec_kind = kind_chip_wipe;
            next_r.exec_stb = 1'b1;
          end
        end
        if (r.state == fcf_data_st && !r.is_read && r.kind != kind_program) begin
          next_r.exec_kind = r.kind;
          next_r.exec_stb = 1'b1;
        end
        // program runs after at least one byte
        if (r.state == fcf_data_st && r.kind == kind_program && r.byte_cnt != 3'd0) begin
          next_r.exec_kind = kind_program;
          next_r.exec_stb = 1'b1;
        end
      end
      next_r.state = fcf_idle_st;
      next_r.io_oe_n = 4'hF;
      next_r.bit_cnt = 4'd0;
      next_r.byte_cnt = 3'd0;
    end else begin
      if (r.state == fcf_idle_st) begin
        next_r.state = fcf_opcode_st;
        next_r.width_in = r.quad_command_mode ? 2'd2 : 2'd0;
        next_r.width_out = r.quad_command_mode ? 2'd2 : 2'd0;
        next_r.kind = kind_none;
        next_r.is_read = 1'b0;
      end
      if (sclk_rise && r.state != fcf_ignore_st && r.state != fcf_idle_st) begin
        next_bits = r.bit_cnt + fcf_step(r.width_in);
        in_byte = fcf_shift_in(r.shift, r.width_in, r.io_s2);
        next_r.shift = in_byte;
        next_r.bit_cnt = next_bits[3] ? 4'd0 : next_bits;
        case (r.state)
          fcf_opcode_st: begin
            if (next_bits[3]) begin
              next_r.opcode = in_byte;
              next_r.last_cmd = in_byte;
              next_r.state = fcf_addr_st;
              next_r.byte_cnt = 3'd0;
              // segment bit above 24 received bits
              next_r.addr = {r.upper_address_byte[0], 24'h0};
              case (in_byte)
                op_read, op_fast_read: begin
                  next_r.is_read = 1'b1;
                  if (r.quad_command_mode) next_r.state = fcf_ignore_st;
                end
                dual_io_fetch_cmd, dual_out_fetch_cmd: begin
                  next_r.is_read = 1'b1;
                  next_r.width_in = in_byte == dual_io_fetch_cmd ? 2'd1 : 2'd0;
                  next_r.width_out = 2'd1;
                  if (r.quad_command_mode) next_r.state = fcf_ignore_st;
                end
                // quad io read, top or bottom start
                quad_io_fetch_cmd, quad_io_fetch_top_cmd: begin
                  next_r.is_read = 1'b1;
                  next_r.width_in = 2'd2;
                  next_r.width_out = 2'd2;
                  next_r.addr = {in_byte == quad_io_fetch_top_cmd, 24'h0};
                end
                quad_out_fetch_cmd: begin
                  next_r.is_read = 1'b1;
                  next_r.width_out = 2'd2;
                  if (r.quad_command_mode) next_r.state = fcf_ignore_st;
                end
                page_program_cmd: next_r.kind = kind_program;
                quad_page_program_cmd: begin
                  next_r.kind = kind_program;
                  if (r.quad_command_mode) next_r.state = fcf_ignore_st;
                end
                wipe_4k_cmd: next_r.kind = kind_wipe_4k;
                wipe_32k_cmd: next_r.kind = kind_wipe_32k;
                wipe_64k_cmd: next_r.kind = kind_wipe_64k;
                chip_wipe_cmd_a, chip_wipe_cmd_b, quad_mode_enter_cmd,
                quad_mode_exit_cmd: begin
                  next_r.state = fcf_opcode_st;
                  next_r.byte_cnt = 3'd1;
                end
                default: next_r.state = fcf_ignore_st;
              endcase
            end
          end
          fcf_addr_st: begin
            if (next_bits[3]) begin
              next_r.byte_cnt = r.byte_cnt + 3'd1;
              // three-byte mode fills low 24 bits only; in four-byte mode the first byte sets bit 24
              case (r.byte_cnt)
                3'd0: if (!r.four_byte_mode) next_r.addr[23:16] = in_byte;
                      else next_r.addr[24] = in_byte[0];
                3'd1: next_r.addr[(r.four_byte_mode ? 23 : 15) -: 8] = in_byte;
                3'd2: next_r.addr[(r.four_byte_mode ? 15 : 7) -: 8] = in_byte;
                default: next_r.addr[7:0] = in_byte;
              endcase
              // four-byte mode takes A24 from the host
              if (r.byte_cnt == (r.four_byte_mode ? 3'd3 : 3'd2)) begin
                next_r.byte_cnt = 3'd0;
                next_r.last_addr = next_r.addr;
                if (r.opcode == op_read) begin
                  next_r.state = fcf_data_st;
                  next_r.array_addr = next_r.addr;
                  next_r.array_rd_stb = 1'b1;
                end else if (r.is_read) begin
                  next_r.state = fcf_dummy_st;
                  next_r.dummy_left = (r.opcode == quad_io_fetch_cmd ||
                                       r.opcode == quad_io_fetch_top_cmd) ?
                                      quad_io_dummy : dummy_base - {r.dummy_sel, 1'b0};
                  next_r.array_addr = next_r.addr;
                  next_r.array_rd_stb = 1'b1;
                end else begin
                  next_r.state = fcf_data_st;
                  next_r.width_in = (r.opcode == quad_page_program_cmd) ? 2'd2 : r.width_in;
                end
              end
            end
          end
          fcf_dummy_st: begin
            next_r.bit_cnt = 4'd0;
            next_r.dummy_left = r.dummy_left - 4'd1;
            if (r.dummy_left == 4'd1) next_r.state = fcf_data_st;
          end
          fcf_data_st: begin
            if (r.is_read) begin
              next_r.bit_cnt = (r.bit_cnt + fcf_step(r.width_out)) & 4'h7;
            end else if (next_bits[3] && r.kind == kind_program) begin
              next_r.prog_data = in_byte;
              next_r.prog_stb = 1'b1;
              next_r.byte_cnt = 3'd1;
            end
          end
          default: begin
          end
        endcase
      end
      if (sclk_fall && r.state == fcf_data_st && r.is_read) begin
        rd_word = (r.bit_cnt == 4'd0) ? array_rdata : r.out_shift;
        next_r.io_oe_n = r.width_out == 2'd2 ? 4'h0 : (r.width_out == 2'd1 ? 4'hC : 4'hD);
        case (r.width_out)
          2'd1: begin
            next_r.io_out = {2'b00, rd_word[7:6]};
            next_r.out_shift = {rd_word[5:0], 2'b00};
          end
          2'd2: begin
            next_r.io_out = rd_word[7:4];
            next_r.out_shift = {rd_word[3:0], 4'h0};
          end
          default: begin
            next_r.io_out = {2'b00, rd_word[7], 1'b0};
            next_r.out_shift = {rd_word[6:0], 1'b0};
          end
        endcase
        if (r.bit_cnt == 4'd0) begin
          next_r.array_addr = r.array_addr + 25'd1;
          next_r.array_rd_stb = 1'b1;
        end
      end
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      r <= '0;
      r.upper_address_byte <= reset_upper_address_byte;
      r.dummy_sel <= reset_dummy_sel;
      r.cs_sync <= 2'h3;
      r.io_oe_n <= 4'hF;
    end else begin
      r <= next_r;
    end
  end
  assign hrdata = r.hrdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign io_out = r.io_out;
  assign io_oe_n = r.io_oe_n;
  assign array_addr = r.array_addr;
  assign array_rd_stb = r.array_rd_stb;
  assign prog_data = r.prog_data;
  assign prog_stb = r.prog_stb;
  assign exec_kind = r.exec_kind;
  assign exec_stb = r.exec_stb;
endmodule

// *** tb/fcf_front_end_chk.sv ***
`timescale 1ns/1ps
module fcf_front_end_chk
  import fcf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic cs_n,
  input wire logic [3:0] io_oe_n,
  input wire logic [24:0] array_addr,
  input wire logic array_rd_stb,
  input wire logic prog_stb,
  input wire logic [2:0] exec_kind,
  input wire logic exec_stb
);
  logic [24:0] last_addr;
  logic seen;
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (rst);
  // seen is only trusted inside one selected frame
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      last_addr <= 25'h0;
      seen <= 1'b0;
    end else begin
      if (array_rd_stb) begin
        last_addr <= array_addr;
      end
      seen <= !cs_n && (seen || array_rd_stb);
    end
  end
  sequence s_upper_read;
    hsel && hready && htrans[1] && !hwrite && haddr == addr_upper_address_segment;
  endsequence
  sequence s_long_idle;
    cs_n [*8];
  endsequence
  a_upper_read_zero: assert property (s_upper_read |=> hrdata[31:1] == 31'h0)
    else $error("upper address bits read nonzero");
  a_stream_step: assert property (
    array_rd_stb && seen && !cs_n |-> array_addr == last_addr + 25'h1)
    else $error("stream address did not step by one");
  a_oe_idle: assert property (cs_n [*6] |-> io_oe_n == 4'hF)
    else $error("pins driven while deselected");
  a_idle_quiet: assert property (s_long_idle |-> !array_rd_stb && !prog_stb && !exec_stb)
    else $error("strobe while deselected");
  a_exec_deselect: assert property (exec_stb |-> cs_n && !$past(cs_n, 8))
    else $error("execute not tied to deselect");
  a_exec_pulse: assert property (exec_stb |=> !exec_stb)
    else $error("execute strobe longer than one cycle");
  a_kind_valid: assert property (
    exec_stb |-> exec_kind >= kind_program && exec_kind <= kind_chip_wipe)
    else $error("execute kind out of range");
  a_rd_pulse: assert property (array_rd_stb |=> !array_rd_stb)
    else $error("read strobe longer than one cycle");
  a_prog_pulse: assert property (prog_stb |=> !prog_stb)
    else $error("program strobe longer than one cycle");
endmodule
bind fcf_front_end fcf_front_end_chk i_chk (.ref_clk(ref_clk), .rst(rst), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .cs_n(cs_n), .io_oe_n(io_oe_n), .array_addr(array_addr), .array_rd_stb(array_rd_stb),
  .prog_stb(prog_stb), .exec_kind(exec_kind), .exec_stb(exec_stb));

// *** tb/fcf_host_model.sv ***
`timescale 1ns/1ps
module fcf_host_model (
  input wire logic ref_clk,
  input wire logic [3:0] io_out,
  output logic sclk,
  output logic cs_n,
  output logic [3:0] io_in
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    io_in = 4'h5;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic open_frame();
    cs_n <= 1'b0;
    tick(4);
  endtask
  // drive on fall, device samples rise
  task automatic shift(input logic [7:0] b, input int ln, input int nbits);
    for (int i = 7; i > 7 - nbits; i -= ln) begin
      io_in <= (ln == 4) ? b[i-:4] : (ln == 2) ? {~io_in[3:2], b[i-:2]} : {~io_in[3:1], b[i]};
      tick(4);
      sclk <= 1'b1;
      tick(4);
      sclk <= 1'b0;
    end
  endtask
  // capture on rise; idle lines toggle
  task automatic fetch(output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      io_in <= ~io_in;
      tick(4);
      sclk <= 1'b1;
      b[i] = io_out[1];
      tick(4);
      sclk <= 1'b0;
    end
  endtask
  task automatic close_frame();
    tick(4);
    cs_n <= 1'b1;
    io_in <= ~io_in;
    tick(12);
  endtask
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import fcf_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rv;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic hready, hreadyout, hresp, sclk, cs_n, array_rd_stb, prog_stb, exec_stb, seg;
  logic [3:0] io_in, io_out, io_oe_n;
  logic [7:0] array_rdata, prog_data, b;
  logic [24:0] array_addr;
  logic [23:0] ra;
  logic [2:0] exec_kind;
  int fail_count = 0, check_count = 0, cyc = 0;
  logic [24:0] rd_q[$];
  logic [7:0] pg_q[$];
  logic [2:0] ex_q[$];
  logic [7:0] ops[6] = '{wipe_4k_cmd, wipe_32k_cmd, wipe_64k_cmd, chip_wipe_cmd_a,
    chip_wipe_cmd_b, page_program_cmd};
  logic [7:0] sl[5] = '{op_read, op_fast_read, dual_io_fetch_cmd, dual_out_fetch_cmd,
    quad_out_fetch_cmd};
  always #20 ref_clk = ~ref_clk;
  assign hready = hreadyout;
  function automatic logic [7:0] pat(input logic [24:0] a);
    return a[7:0] ^ {a[24], a[22:16]};
  endfunction
  function automatic logic [2:0] kind_of(input logic [7:0] op);
    case (op)
      wipe_4k_cmd: return kind_wipe_4k;
      wipe_32k_cmd: return kind_wipe_32k;
      wipe_64k_cmd: return kind_wipe_64k;
      page_program_cmd: return kind_program;
      default: return kind_chip_wipe;
    endcase
  endfunction
  assign array_rdata = pat(array_addr);
  fcf_front_end i_dut (.ref_clk(ref_clk), .rst(rst), .haddr_sel(1'b0), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sclk(sclk),
    .cs_n(cs_n), .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n),
    .array_rdata(array_rdata), .array_addr(array_addr), .array_rd_stb(array_rd_stb),
    .prog_data(prog_data), .prog_stb(prog_stb), .exec_kind(exec_kind), .exec_stb(exec_stb));
  fcf_host_model i_host (.ref_clk(ref_clk), .io_out(io_out), .sclk(sclk), .cs_n(cs_n),
    .io_in(io_in));
  always @(posedge ref_clk) begin
    if (array_rd_stb) rd_q.push_back(array_addr);
    if (prog_stb) pg_q.push_back(prog_data);
    if (exec_stb) ex_q.push_back(exec_kind);
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    // no test should come near this many cycles
    if (cyc == 40000) begin
      fail_count++;
      final_report();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge ref_clk);
    while (hready !== 1'b1) @(posedge ref_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge ref_clk);
    while (hready !== 1'b1) @(posedge ref_clk);
    rv = hrdata;
  endtask
  task automatic cmd(input logic [7:0] op, input int ln, input logic [23:0] a, input int na);
    i_host.open_frame();
    i_host.shift(op, ln, 8);
    for (int i = 0; i < na; i++) i_host.shift(a[23-8*i-:8], ln, 8);
  endtask
  initial begin
    void'($urandom(32'h31796CC5));
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    ahb(addr_upper_address_segment, 1'b0, 32'h0);
    check(rv, 32'h0);
    ahb(addr_upper_address_segment, 1'b1, 32'hFF);
    ahb(addr_upper_address_segment, 1'b0, 32'h0);
    check(rv, 32'h1);
    ahb(32'h0000_0040, 1'b0, 32'h0);
    check(rv, 32'h0);
    // first pass crosses a segment end
    for (int k = 0; k < 6; k++) begin
      seg = (k == 0) ? 1'b0 : 1'($urandom);
      ra = (k == 0) ? 24'hFFFFFF : 24'($urandom);
      ahb(addr_upper_address_segment, 1'b1, {31'h0, seg});
      rd_q.delete();
      cmd(op_read, 1, ra, 3);
      i_host.fetch(b);
      check(b, pat({seg, ra}));
      i_host.fetch(b);
      check(b, pat({seg, ra} + 25'h1));
      i_host.close_frame();
      check(rd_q[0], {seg, ra});
      check(rd_q[1], {seg, ra} + 25'h1);
      ahb(addr_upper_address_segment, 1'b0, 32'h0);
      check(rv, {31'h0, seg});
    end
    for (int k = 0; k < 6; k++) begin
      ex_q.delete();
      pg_q.delete();
      cmd(ops[k], 1, 24'($urandom), (k == 3 || k == 4) ? 0 : 3);
      if (k == 5) begin
        i_host.shift(8'hA5, 1, 8);
        i_host.shift(8'h3C, 1, 8);
      end
      i_host.close_frame();
      check(ex_q.size(), 1);
      check(ex_q[0], kind_of(ops[k]));
    end
    check(pg_q[0], 8'hA5);
    check(pg_q[1], 8'h3C);
    ex_q.delete();
    cmd(wipe_4k_cmd, 1, 24'h001000, 3);
    i_host.shift(8'hF0, 1, 4);
    i_host.close_frame();
    check(ex_q.size(), 0);
    // fast, dual and quad-output fetches: one dummy clock short, then exact, per select
    for (int k = 0; k < 4; k++) begin
      ra = 24'($urandom);
      ahb(addr_mode_control, 1'b1, {24'h0, 2'(k), 6'h00});
      for (int n = 7 - 2 * k; n < 9 - 2 * k; n++) begin
        rd_q.delete();
        i_host.open_frame();
        i_host.shift(sl[k + 1], 1, 8);
        for (int i = 0; i < 3; i++) i_host.shift(ra[23-8*i-:8], (k == 1) ? 2 : 1, 8);
        i_host.shift(8'h00, 1, n);
        i_host.close_frame();
        check(rd_q.size(), n + 2 * k - 6);
        check(rd_q[0], {seg, ra});
      end
    end
    ahb(addr_mode_control, 1'b1, 32'h2);
    cmd(quad_mode_enter_cmd, 1, 24'h0, 0);
    i_host.close_frame();
    ahb(addr_status, 1'b0, 32'h0);
    check(rv[2:1], 2'h3);
    foreach (sl[k]) begin
      rd_q.delete();
      cmd(sl[k], 4, 24'($urandom), 3);
      i_host.shift(8'h00, 4, 8);
      i_host.close_frame();
      check(rd_q.size(), 0);
    end
    // segment register set opposite to the opcode's own segment
    for (int k = 0; k < 2; k++) begin
      ra = 24'($urandom);
      ahb(addr_upper_address_segment, 1'b1, {31'h0, k == 0});
      rd_q.delete();
      cmd(k ? quad_io_fetch_top_cmd : quad_io_fetch_cmd, 4, ra, 3);
      repeat (4) i_host.shift(8'h00, 4, 8);
      i_host.close_frame();
      check(rd_q[0], {k[0], ra});
    end
    cmd(quad_mode_exit_cmd, 4, 24'h0, 0);
    i_host.close_frame();
    ahb(addr_status, 1'b0, 32'h0);
    check(rv[2:1], 2'h1);
    final_report();
  end
endmodule
